// ===== hdl/tpdo_mapping_emcy_framer.sv
`timescale 1ns/100ps
module tpdo_mapping_emcy_framer
  import tpdo_emcy_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic errEvent,
  input wire err_event_s errInfo,
  input wire logic errCausesActive,
  output emcy_frame_s emcyFrame,
  output logic emcyValid,
  input wire logic emcyReady,
  output logic [NUM_TPDO-1:0] tpdoEnable,
  output logic faultState
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] defaultEntry(input int tp, input int slot);
    logic [31:0] e;
    e = 32'h0000_0000;
    if (slot == 0)
      e = MAP_STATUS;
    else if (slot == 1)
      case (tp)
        0: e = MAP_MODE;
        1: e = MAP_POSITION;
        2: e = MAP_VELOCITY;
        default: e = MAP_TORQUE;
      endcase
    else if (slot == 2 && tp == 0)
      e = MAP_INPUTS;
    return e;
  endfunction : defaultEntry

  // Only the process values this drive can actually sample are mappable
  function automatic logic [31:0] checkEntry(input logic [31:0] e);
    logic [31:0] code;
    code = ABORT_NO_OBJECT;
    // index [31:16], sub-index [15:8], length [7:0]
    case (e[31:8])
      MAP_STATUS[31:8], MAP_MODE[31:8], MAP_INPUTS[31:8], MAP_POSITION[31:8], MAP_VELOCITY[31:8],
      MAP_TORQUE[31:8]:
        code = (e == MAP_STATUS || e == MAP_MODE || e == MAP_INPUTS || e == MAP_POSITION ||
                e == MAP_VELOCITY || e == MAP_TORQUE) ? ABORT_NONE : ABORT_NOT_MAPPABLE;
      default: code = ABORT_NO_OBJECT;
    endcase
    return code;
  endfunction : checkEntry

  function automatic logic [31:0] checkCount(input map_tab_t t, input logic [31:0] n);
    logic [31:0] code;
    logic [8:0] bits;
    code = ABORT_NONE;
    bits = 9'h000;
    if (n > 32'(MAP_SLOTS))
      code = ABORT_MAP_LENGTH;
    else
    begin
      for (int i = 0; i < MAP_SLOTS; i++)
        if (32'(i) < n)
        begin
          bits = bits + {1'b0, t[i][7:0]};
          if (checkEntry(t[i]) != ABORT_NONE)
            code = ABORT_NO_OBJECT;
        end
      if (code == ABORT_NONE && bits > 9'(PDO_MAX_BITS))
        code = ABORT_MAP_LENGTH;
    end
    return code;
  endfunction : checkCount

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : mergeBytes

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  map_tab_t mapTab_r [NUM_TPDO];
  logic [3:0] mapCnt_r [NUM_TPDO];
  logic [31:0] cobTab_r [NUM_TPDO];
  logic [15:0] hist_r [HIST_DEPTH];
  logic [3:0] histCnt_r;
  logic preOp_r;
  logic [6:0] node_r;
  logic [31:0] abort_r;
  logic [15:0] lastCode_r;
  logic [7:0] errReg_r;
  err_state_e errState_r;
  logic awHave_r;
  logic wHave_r;
  logic [11:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic emcyValid_r;
  emcy_frame_s emcyFrame_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [33:0] regRead(input logic [11:0] a);
    logic [33:0] r;
    logic [1:0] tp;
    logic [3:0] sub;
    r = {RESP_DECERR, 32'h0000_0000};
    tp = a[7:6];
    sub = a[5:2];
    if (a == ADDR_CTRL)
      r = {RESP_OKAY, 31'h0000_0000, preOp_r};
    else if (a == ADDR_NODE)
      r = {RESP_OKAY, 25'h000_0000, node_r};
    else if (a == ADDR_ABORT)
      r = {RESP_OKAY, abort_r};
    else if (a == ADDR_ERRCODE)
      r = {RESP_OKAY, 16'h0000, lastCode_r};
    else if (a == ADDR_STATUS)
      r = {RESP_OKAY, 16'h0000, histCnt_r, 3'h0, errState_r == ERR_FAULT, errReg_r};
    else if (a[11:6] == PAGE_HIST && a[5:2] != 4'h0)
      r = {RESP_OKAY, 16'h0000, hist_r[a[5:2] - 4'h1]};
    else if (a[11:8] == PAGE_MAP && sub == 4'h0)
      r = {RESP_OKAY, 28'h000_0000, mapCnt_r[tp]};
    else if (a[11:8] == PAGE_MAP && sub <= 4'(MAP_SLOTS))
      r = {RESP_OKAY, mapTab_r[tp][sub[2:0] - 3'h1]};
    else if (a[11:4] == PAGE_COB)
      r = {RESP_OKAY, cobTab_r[a[3:2]] + {25'h000_0000, node_r}};
    return r;
  endfunction : regRead

  wire doWrite = awHave_r && wHave_r && !bValid_r;
  // A process, not an assign: it must follow every register that the decoder reads
  logic [33:0] wrOld;
  logic [33:0] rdWord;
  always_comb
  begin
    wrOld = regRead(awAddr_r);
    rdWord = regRead(s_axi_araddr);
  end
  wire [31:0] wrVal = mergeBytes(wrOld[31:0], wData_r, wStrb_r);
  wire [1:0] wrTp = awAddr_r[7:6];
  wire [3:0] wrSub = awAddr_r[5:2];
  wire wrIsMap = awAddr_r[11:8] == PAGE_MAP && wrSub <= 4'(MAP_SLOTS);
  wire wrIsCnt = wrIsMap && wrSub == 4'h0;
  wire wrIsEntry = wrIsMap && wrSub != 4'h0;
  wire wrIsCob = awAddr_r[11:4] == PAGE_COB;
  wire wrIsCtrl = awAddr_r == ADDR_CTRL;
  wire wrIsNode = awAddr_r == ADDR_NODE;
  wire wrIsAbort = awAddr_r == ADDR_ABORT;
  wire wrMapped = wrIsMap || wrIsCob || wrIsCtrl || wrIsNode || wrIsAbort;

  // Mapping edits need pre-op, and entries need the count held at zero first
  wire [31:0] entryCode = (!preOp_r || mapCnt_r[wrTp] != 4'h0) ? ABORT_STATE : checkEntry(wrVal);
  wire [31:0] cntCode = !preOp_r ? ABORT_STATE :
                        wrVal == 32'h0000_0000 ? ABORT_NONE :
                        mapCnt_r[wrTp] != 4'h0 ? ABORT_STATE : checkCount(mapTab_r[wrTp], wrVal);
  wire [31:0] wrCode = wrIsEntry ? entryCode : wrIsCnt ? cntCode : ABORT_NONE;
  wire wrAccept = doWrite && wrMapped && wrCode == ABORT_NONE;
  wire [1:0] wrResp = !wrMapped ? RESP_DECERR : (wrCode != ABORT_NONE) ? RESP_SLVERR : RESP_OKAY;
  wire initPulse = wrAccept && wrIsCtrl && wrVal[CTRL_INIT];
  wire ackPulse = wrAccept && wrIsCtrl && wrVal[CTRL_ACK];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHave_r;
  assign s_axi_wready = !wHave_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !awHave_r)
      begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r)
      begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        bValid_r <= 1'b1;
        bResp_r <= wrResp;
      end
      else if (bValid_r && s_axi_bready)
      begin
        bValid_r <= 1'b0;
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rValid_r)
    begin
      rValid_r <= 1'b1;
      rData_r <= rdWord[31:0];
      rResp_r <= rdWord[33:32];
    end
    else if (rValid_r && s_axi_rready)
      rValid_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Mapping tables and communication objects
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int t = 0; t < NUM_TPDO; t++)
      begin
        for (int s = 0; s < MAP_SLOTS; s++)
          mapTab_r[t][s] <= defaultEntry(t, s);
        mapCnt_r[t] <= (t == 0) ? CNT_TPDO1 : CNT_OTHER;
        cobTab_r[t] <= COB_BASE_TPDO + 32'(t) * COB_STEP_TPDO;
      end
      preOp_r <= 1'b0;
      node_r <= 7'h01;
      abort_r <= ABORT_NONE;
    end
    else if (doWrite)
    begin
      if (wrCode != ABORT_NONE)
        abort_r <= wrCode;
      else if (wrAccept && wrIsAbort)
        abort_r <= ABORT_NONE;
      if (wrAccept && wrIsEntry)
        mapTab_r[wrTp][wrSub[2:0] - 3'h1] <= wrVal;
      if (wrAccept && wrIsCnt)
        mapCnt_r[wrTp] <= wrVal[3:0];
      if (wrAccept && wrIsCob)
        cobTab_r[awAddr_r[3:2]] <= {wrVal[31], 20'h0_0000, wrVal[10:0] - {4'h0, node_r}};
      if (wrAccept && wrIsCtrl)
        preOp_r <= wrVal[CTRL_PREOP];
      if (wrAccept && wrIsNode)
        node_r <= wrVal[6:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TPDO; g++)
    begin : gTpdo
      assign tpdoEnable[g] = !cobTab_r[g][COB_VALID_BIT] && mapCnt_r[g] != 4'h0;
      a_tpdo_gate: assert property (@(posedge mclk) disable iff (rst)
        (wrAccept && wrIsCnt && wrTp == 2'(g) && wrVal == 32'h0000_0000) |=> !tpdoEnable[g])
        else $error("TPDO still enabled after mapping count cleared");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Error state and emergency framing
  // ----------------------------------------------------------------
  wire newError = errEvent && errInfo.code != EMCY_NO_ERROR;
  wire ackClears = ackPulse && !errCausesActive && errState_r == ERR_FAULT;
  wire [15:0] frameCode = newError ? errInfo.code : EMCY_NO_ERROR;
  wire [7:0] frameReg = newError ? (errInfo.errClass | ERR_GENERIC) : 8'h00;
  // The frame carries the accumulated error register, not only the new class
  wire [7:0] errReg_nxt = newError ? (errReg_r | frameReg) : ackClears ? 8'h00 : errReg_r;
  wire [39:0] frameMfr = newError ? errInfo.mfr : initPulse ? {24'h00_0000, CAN_STATE_CODE[15:8], CAN_STATE_CODE[7:0]} :
                         40'h00_0000_0000;
  wire sendFrame = newError || initPulse || ackClears;

  assign faultState = errState_r == ERR_FAULT;
  assign emcyValid = emcyValid_r;
  assign emcyFrame = emcyFrame_r;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      errState_r <= ERR_IDLE;
      errReg_r <= 8'h00;
      lastCode_r <= EMCY_NO_ERROR;
      histCnt_r <= 4'h0;
      for (int i = 0; i < HIST_DEPTH; i++)
        hist_r[i] <= EMCY_NO_ERROR;
      emcyValid_r <= 1'b0;
      emcyFrame_r <= '0;
    end
    else
    begin
      // A new error wins over an acknowledge in the same cycle
      if (newError)
      begin
        errState_r <= ERR_FAULT;
        errReg_r <= errReg_nxt;
        lastCode_r <= errInfo.code;
        hist_r[0] <= errInfo.code;
        for (int i = 1; i < HIST_DEPTH; i++)
          hist_r[i] <= hist_r[i-1];
        if (histCnt_r != 4'(HIST_DEPTH))
          histCnt_r <= histCnt_r + 4'h1;
      end
      else if (ackClears)
      begin
        errState_r <= ERR_IDLE;
        errReg_r <= errReg_nxt;
        lastCode_r <= EMCY_NO_ERROR;
      end
      // Otherwise a failed acknowledge leaves the fault standing
      if (sendFrame)
      begin
        // Latest event replaces an unsent frame: the newest state matters most
        emcyValid_r <= 1'b1;
        emcyFrame_r.id <= EMCY_BASE_ID + {4'h0, node_r};
        emcyFrame_r.dlc <= 4'h8;
        emcyFrame_r.data <= {frameMfr, errReg_nxt, frameCode[15:8], frameCode[7:0]};
      end
      else if (emcyReady)
        emcyValid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fault_entry: assert property (@(posedge mclk) disable iff (rst)
    (errState_r == ERR_IDLE && newError) |=> faultState && emcyValid && emcyFrame.data[15:0] == $past(errInfo.code))
    else $error("First error did not enter fault with emergency frame");
  a_hist_newest: assert property (@(posedge mclk) disable iff (rst)
    newError |=> hist_r[0] == $past(errInfo.code) && hist_r[1] == $past(hist_r[0]))
    else $error("History did not shift in newest code");
  a_last_code: assert property (@(posedge mclk) disable iff (rst)
    newError |=> lastCode_r == $past(errInfo.code))
    else $error("Latest error code not stored");
  a_ack_stay: assert property (@(posedge mclk) disable iff (rst)
    (faultState && ackPulse && errCausesActive) |=> faultState [*2])
    else $error("Failed acknowledge left fault state");
  a_ack_clear: assert property (@(posedge mclk) disable iff (rst)
    (ackClears && !newError) |=> !faultState && emcyValid && emcyFrame.data[23:0] == 24'h00_0000)
    else $error("Successful acknowledge did not send no-error frame");
  a_generic_bit: assert property (@(posedge mclk) disable iff (rst)
    faultState |-> errReg_r[0])
    else $error("Generic error bit clear in fault state");
  a_emcy_id: assert property (@(posedge mclk) disable iff (rst)
    $rose(emcyValid) |-> emcyFrame.id == EMCY_BASE_ID + {4'h0, node_r} && emcyFrame.data[23:16] == errReg_r)
    else $error("Emergency identifier or register byte wrong");
  a_remap_locked: assert property (@(posedge mclk) disable iff (rst)
    (doWrite && wrIsMap && !preOp_r) |=> s_axi_bresp == RESP_SLVERR && $stable(mapCnt_r[0]) &&
      $stable(mapCnt_r[1]) && $stable(mapCnt_r[2]) && $stable(mapCnt_r[3]))
    else $error("Mapping changed outside pre-operational");
  a_count_abort: assert property (@(posedge mclk) disable iff (rst)
    (doWrite && wrIsCnt && preOp_r && mapCnt_r[wrTp] == 4'h0 && wrVal > 32'(MAP_SLOTS))
      |=> abort_r == ABORT_MAP_LENGTH && s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("Oversized mapping count not aborted");
  a_init_frame: assert property (@(posedge mclk) disable iff (rst)
    (initPulse && !newError) |=> emcyFrame.data[15:0] == EMCY_NO_ERROR && emcyFrame.data[31:24] == CAN_STATE_CODE[7:0])
    else $error("Init frame lacks no-error or CAN state");

  c_fault: cover property (@(posedge mclk) disable iff (rst) errState_r == ERR_IDLE && newError);
  c_ack_clear: cover property (@(posedge mclk) disable iff (rst) ackClears);
  c_abort: cover property (@(posedge mclk) disable iff (rst) doWrite && wrResp == RESP_SLVERR);
  c_hist_full: cover property (@(posedge mclk) disable iff (rst) histCnt_r == 4'(HIST_DEPTH));

endmodule : tpdo_mapping_emcy_framer

// ===== inc/tpdo_emcy_pkg.sv
package tpdo_emcy_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_NODE = 12'h004;
  localparam logic [11:0] ADDR_ABORT = 12'h008;
  localparam logic [11:0] ADDR_ERRCODE = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [5:0] PAGE_HIST = 6'h01;
  localparam logic [3:0] PAGE_MAP = 4'h1;
  localparam logic [7:0] PAGE_COB = 8'h20;
  localparam int CTRL_PREOP = 0;
  localparam int CTRL_INIT = 1;
  localparam int CTRL_ACK = 2;
  localparam int COB_VALID_BIT = 31;

  // ----------------------------------------------------------------
  // Mapping constants
  // ----------------------------------------------------------------
  localparam int NUM_TPDO = 4;
  localparam int MAP_SLOTS = 8;
  localparam int PDO_MAX_BITS = 64;
  localparam int HIST_DEPTH = 15;
  localparam logic [31:0] MAP_STATUS = 32'h6041_0010;
  localparam logic [31:0] MAP_MODE = 32'h6061_0008;
  localparam logic [31:0] MAP_INPUTS = 32'h60FD_0020;
  localparam logic [31:0] MAP_POSITION = 32'h6064_0020;
  localparam logic [31:0] MAP_VELOCITY = 32'h606C_0020;
  localparam logic [31:0] MAP_TORQUE = 32'h6077_0010;
  localparam logic [3:0] CNT_TPDO1 = 4'h3;
  localparam logic [3:0] CNT_OTHER = 4'h2;
  localparam logic [31:0] COB_BASE_TPDO = 32'h0000_0180;
  localparam logic [31:0] COB_STEP_TPDO = 32'h0000_0100;

  // ----------------------------------------------------------------
  // Abort and emergency codes
  // ----------------------------------------------------------------
  localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_NOT_MAPPABLE = 32'h0604_0041;
  localparam logic [31:0] ABORT_MAP_LENGTH = 32'h0604_0042;
  localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
  localparam logic [15:0] EMCY_NO_ERROR = 16'h0000;
  localparam logic [15:0] CAN_STATE_CODE = 16'h8170;
  localparam logic [10:0] EMCY_BASE_ID = 11'h080;
  localparam logic [7:0] ERR_GENERIC = 8'h01;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef logic [MAP_SLOTS-1:0][31:0] map_tab_t;

  typedef enum logic {ERR_IDLE, ERR_FAULT} err_state_e;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } emcy_frame_s;

  typedef struct packed {
    logic [15:0] code;
    logic [7:0] errClass;
    logic [39:0] mfr;
  } err_event_s;

endpackage : tpdo_emcy_pkg

// ===== bench/emcy_sink.sv
`timescale 1ns/100ps
module emcy_sink
  import tpdo_emcy_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire emcy_frame_s emcyFrame,
  input wire logic emcyValid,
  input wire logic stall,
  output logic emcyReady,
  output emcy_frame_s lastFrame,
  output logic [7:0] frameCount
);
  // Stalling stands for a busy bus, so the framer must hold its frame
  assign emcyReady = !stall;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lastFrame <= '0;
      frameCount <= 8'h00;
    end
    else if (emcyValid && emcyReady)
    begin
      lastFrame <= emcyFrame;
      frameCount <= frameCount + 8'h01;
    end
  end
endmodule : emcy_sink

// ===== bench/tpdo_mapping_emcy_framer_tb.sv
`timescale 1ns/100ps
module tpdo_mapping_emcy_framer_tb import tpdo_emcy_pkg::*;;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic errEvent = 1'h0, causes = 1'h0, stall = 1'h1;
  err_event_s errInfo = '0;
  logic awready, wready, bvalid, arready, rvalid, emcyValid, emcyReady, faultState;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] tpdoEnable;
  logic [7:0] frameCount;
  emcy_frame_s emcyFrame, lastFrame;
  int n_mismatch = 0, n_checks = 0;
  localparam logic [31:0] dm [4][4] = '{'{32'h3, MAP_STATUS, MAP_MODE, MAP_INPUTS},
    '{32'h2, MAP_STATUS, MAP_POSITION, 32'h0}, '{32'h2, MAP_STATUS, MAP_VELOCITY, 32'h0},
    '{32'h2, MAP_STATUS, MAP_TORQUE, 32'h0}};
  always #4 mclk = ~mclk;
  tpdo_mapping_emcy_framer uut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .errEvent(errEvent),
    .errInfo(errInfo), .errCausesActive(causes), .emcyFrame(emcyFrame), .emcyValid(emcyValid),
    .emcyReady(emcyReady), .tpdoEnable(tpdoEnable), .faultState(faultState));
  emcy_sink sink (.mclk(mclk), .rst(rst), .emcyFrame(emcyFrame), .emcyValid(emcyValid), .stall(stall),
    .emcyReady(emcyReady), .lastFrame(lastFrame), .frameCount(frameCount));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // Unanswered requests leave the last response the bus still holds, which the compare then checks
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 1'h0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb && n < 40)
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    chk(64'(r), 64'(er));
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [33:0] g;
    n = 0;
    tr = 1'h0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr && n < 40)
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      g = {rresp, rdata};
      @(posedge mclk);
      if (ta)
        arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    chk(64'(g), 64'({er, e}));
  endtask : rd
  task automatic ev(input logic [15:0] code, input logic [7:0] cls);
    @(posedge mclk);
    errEvent <= 1'h1;
    errInfo <= '{code, cls, 40'h0};
    @(posedge mclk);
    errEvent <= 1'h0;
  endtask : ev
  task automatic frm(input logic [63:0] e, input logic [63:0] m);
    int n;
    logic [7:0] c;
    n = 0;
    repeat (3) @(negedge mclk);
    chk(64'(emcyValid), 64'h1);
    c = frameCount;
    @(posedge mclk);
    stall <= 1'h0;
    while (frameCount == c && n < 40)
    begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    stall <= 1'h1;
    chk(64'({lastFrame.id, lastFrame.dlc}), 64'({EMCY_BASE_ID + 11'h001, 4'h8}));
    chk(lastFrame.data & m, e);
  endtask : frm
  task automatic t_defaults;
    chk(64'(tpdoEnable), 64'hF);
    for (int t = 0; t < 4; t++)
      for (int s = 0; s < 4; s++)
        rd(12'h100 + 12'(t * 64 + s * 4), dm[t][s], RESP_OKAY);
    rd(12'h200, 32'h181, RESP_OKAY);
    wr(12'h0F0, 32'h1, RESP_DECERR);
    rd(12'h0F0, 32'h0, RESP_DECERR);
    $display("defaults done");
  endtask : t_defaults
  task automatic t_remap;
    wr(12'h104, MAP_POSITION, RESP_SLVERR);
    rd(ADDR_ABORT, ABORT_STATE, RESP_OKAY);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    wr(12'h104, MAP_POSITION, RESP_SLVERR);
    wr(12'h200, 32'h8000_0181, RESP_OKAY);
    chk(64'(tpdoEnable), 64'hE);
    wr(12'h100, 32'h0, RESP_OKAY);
    wr(12'h104, 32'h1234_0010, RESP_SLVERR);
    rd(ADDR_ABORT, ABORT_NO_OBJECT, RESP_OKAY);
    wr(12'h104, 32'h6041_0020, RESP_SLVERR);
    rd(ADDR_ABORT, ABORT_NOT_MAPPABLE, RESP_OKAY);
    wr(12'h104, MAP_POSITION, RESP_OKAY);
    wr(12'h108, MAP_VELOCITY, RESP_OKAY);
    wr(12'h10C, MAP_INPUTS, RESP_OKAY);
    wr(12'h100, 32'h3, RESP_SLVERR);
    rd(ADDR_ABORT, ABORT_MAP_LENGTH, RESP_OKAY);
    wr(12'h100, 32'h9, RESP_SLVERR);
    wr(12'h200, 32'h0000_0181, RESP_OKAY);
    chk(64'(tpdoEnable), 64'hE);
    wr(12'h100, 32'h2, RESP_OKAY);
    chk(64'(tpdoEnable), 64'hF);
    rd(12'h108, MAP_VELOCITY, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("remap done");
  endtask : t_remap
  task automatic t_errors;
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    frm(64'h0000_0081_7000_0000, '1);
    ev(16'h2340, 8'h02);
    frm(64'h0000_0000_0003_2340, '1);
    chk(64'(faultState), 64'h1);
    rd(ADDR_ERRCODE, 32'h2340, RESP_OKAY);
    ev(16'h3210, 8'h04);
    frm(64'h0000_0000_0007_3210, '1);
    rd(12'h044, 32'h3210, RESP_OKAY);
    rd(12'h048, 32'h2340, RESP_OKAY);
    rd(ADDR_STATUS, 32'h2107, RESP_OKAY);
    @(posedge mclk);
    causes <= 1'h1;
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    repeat (2) @(negedge mclk);
    chk(64'({faultState, emcyValid}), 64'h2);
    @(posedge mclk);
    causes <= 1'h0;
    wr(ADDR_CTRL, 32'h4, RESP_OKAY);
    frm(64'h0, 64'hFF_FFFF);
    chk(64'(faultState), 64'h0);
    rd(ADDR_ERRCODE, 32'h0, RESP_OKAY);
    for (int i = 0; i < 14; i++)
      ev(16'h5000 + 16'(i), 8'h00);
    rd(12'h044, 32'h500D, RESP_OKAY);
    rd(12'h07C, 32'h3210, RESP_OKAY);
    $display("errors done");
  endtask : t_errors
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    t_defaults;
    t_remap;
    t_errors;
    test_done;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule : tpdo_mapping_emcy_framer_tb
